// ==== ppp_pkg.sv ====
// Purpose: Shared constants and types for the parallel printer port
// Assumes: 250 MHz clock, synchronous active-high reset
// Notes: Strobe timing counts are derived from times in ns
package ppp_pkg;

    localparam int CLK_PERIOD_NS = 4;
    // Setup, strobe and hold times in ns
    localparam int SETUP_NS = 500;
    localparam int STROBE_NS = 1000;
    localparam int HOLD_NS = 500;
    localparam int SETUP_CYC = (SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int STROBE_CYC =
        (STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int HOLD_CYC = (HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CNT_W = 10;

    localparam logic [7:0] DATA_RST = 8'h00;
    localparam logic [1:0] MODE_RST = 2'h0;
    localparam logic IRQ_SEL_RST = 1'h0;

    typedef enum logic [1:0] {
        PPP_MODE_COMPAT = 2'h0,
        PPP_MODE_BIDIR = 2'h1,
        PPP_MODE_FAST = 2'h2
    } ppp_mode_t;

    typedef enum logic [2:0] {
        PPP_ST_IDLE = 3'h0,
        PPP_ST_SETUP = 3'h1,
        PPP_ST_STROBE = 3'h2,
        PPP_ST_HOLD = 3'h3,
        PPP_ST_WAIT = 3'h4
    } ppp_state_t;

    // Status lines from the peripheral, all in true-level form
    typedef struct packed {
        logic busy;
        logic ack;
        logic fault;
        logic paper_out;
        logic selected;
    } ppp_status_t;

    // Control strobes to the peripheral, active-low as on the pins
    typedef struct packed {
        logic print_strobe_n;
        logic auto_line_feed_n;
        logic printer_init_n;
        logic select_in_n;
    } ppp_ctrl_t;

endpackage

// ==== ppp_port.sv ====
// Purpose: Parallel printer port, host end, pin-level sequencer
// Assumes: One byte request at a time from the user side
// Notes: Status inputs pass the three-stage synchroniser
`timescale 1ns/1ps
module ppp_port (
    input wire logic clk,
    input wire logic reset,
    input wire logic [1:0] mode_sel,
    input wire logic irq_line_sel,
    input wire logic irq_enable,
    input wire logic auto_feed_req,
    input wire logic init_req,
    input wire logic select_req,
    input wire logic req_valid,
    input wire logic req_read,
    input wire logic req_addr,
    input wire logic [7:0] req_data,
    output logic req_ready,
    output logic rsp_valid,
    output logic [7:0] rsp_data,
    output ppp_pkg::ppp_status_t status,
    output ppp_pkg::ppp_ctrl_t ctrl,
    output logic [7:0] port_data_out,
    output logic [7:0] port_data_oe,
    input wire logic [7:0] port_data_in,
    output logic data_buffer_direction,
    input wire logic peripheral_busy,
    input wire logic peripheral_ack_n,
    input wire logic peripheral_fault_n,
    input wire logic paper_out,
    input wire logic peripheral_selected,
    output logic irq7_out,
    output logic irq7_oe,
    output logic irq5_out,
    output logic irq5_oe
);

    typedef struct packed {
        ppp_pkg::ppp_state_t fsm;
        ppp_pkg::ppp_mode_t mode;
        logic [ppp_pkg::CNT_W-1:0] cnt;
        logic rd;
        logic addr;
        logic [7:0] dout;
        logic [7:0] oe;
        logic dir;
        ppp_pkg::ppp_ctrl_t ctrl;
        logic ready;
        logic rsp_v;
        logic [7:0] rsp;
        logic ack_prev;
        logic irq7;
        logic irq7_oe;
        logic irq5;
        logic irq5_oe;
        logic ack_seen;
        ppp_pkg::ppp_status_t stat;
    } ppp_port_state_t;

    ppp_port_state_t st_ff;
    ppp_port_state_t nxt_st;
    logic [4:0] raw_in;
    logic [4:0] sy_in;
    logic [7:0] sy_data;
    logic ack_fall;

    assign ack_fall = !sy_in[3] && st_ff.ack_prev;
    assign raw_in = {peripheral_busy, peripheral_ack_n, peripheral_fault_n,
                     paper_out, peripheral_selected};

    ppp_sync #(.WIDTH(5), .RST_VAL(5'h0c)) u_sync_stat (
        .clk(clk),
        .reset(reset),
        .din(raw_in),
        .dout(sy_in)
    );

    ppp_sync #(.WIDTH(8), .RST_VAL(8'h00)) u_sync_data (
        .clk(clk),
        .reset(reset),
        .din(port_data_in),
        .dout(sy_data)
    );

    function automatic logic [ppp_pkg::CNT_W-1:0] cyc(input int n);
        cyc = ppp_pkg::CNT_W'(n - 1);
    endfunction

    always_comb begin
        nxt_st = st_ff;
        nxt_st.rsp_v = 1'b0;
        // Status inputs presented in true-level form
        nxt_st.stat.busy = sy_in[4];
        nxt_st.stat.ack = ~sy_in[3];
        nxt_st.stat.fault = ~sy_in[2];
        nxt_st.stat.paper_out = sy_in[1];
        nxt_st.stat.selected = sy_in[0];
        nxt_st.ack_prev = sy_in[3];
        if (st_ff.cnt != '0) begin
            nxt_st.cnt = st_ff.cnt - 1'b1;
        end
        // Ack may arrive before hold ends; remember it
        if (ack_fall && (st_ff.fsm == ppp_pkg::PPP_ST_STROBE ||
            st_ff.fsm == ppp_pkg::PPP_ST_HOLD)) begin
            nxt_st.ack_seen = 1'b1;
        end
        nxt_st.ctrl.printer_init_n = ~init_req;
        unique case (st_ff.fsm)
            ppp_pkg::PPP_ST_IDLE: begin
                nxt_st.ready = 1'b1;
                if (mode_sel <= 2'h2) begin
                    nxt_st.mode = ppp_pkg::ppp_mode_t'(mode_sel);
                end
                if (st_ff.mode != ppp_pkg::PPP_MODE_FAST) begin
                    nxt_st.ctrl.auto_line_feed_n = ~auto_feed_req;
                    nxt_st.ctrl.select_in_n = ~select_req;
                end else begin
                    nxt_st.ctrl.auto_line_feed_n = 1'b1;
                    nxt_st.ctrl.select_in_n = 1'b1;
                end
                if (nxt_st.mode == ppp_pkg::PPP_MODE_COMPAT) begin
                    nxt_st.dir = 1'b0;
                    nxt_st.oe = 8'hff;
                end
                if (req_valid && st_ff.ready && !(req_read &&
                    nxt_st.mode == ppp_pkg::PPP_MODE_COMPAT)) begin
                    nxt_st.ready = 1'b0;
                    nxt_st.ack_seen = 1'b0;
                    nxt_st.rd = req_read;
                    nxt_st.addr = req_addr;
                    if (req_read) begin
                        nxt_st.dir = 1'b1;
                        nxt_st.oe = 8'h00;
                    end else begin
                        nxt_st.dir = 1'b0;
                        nxt_st.oe = 8'hff;
                        nxt_st.dout = req_data;
                    end
                    nxt_st.cnt = cyc(ppp_pkg::SETUP_CYC);
                    nxt_st.fsm = ppp_pkg::PPP_ST_SETUP;
                end
            end
            ppp_pkg::PPP_ST_SETUP: begin
                // Busy stalls the strobe; no timeout by design
                if (st_ff.cnt == '0 && !st_ff.stat.busy) begin
                    nxt_st.cnt = cyc(ppp_pkg::STROBE_CYC);
                    nxt_st.fsm = ppp_pkg::PPP_ST_STROBE;
                    if (st_ff.mode != ppp_pkg::PPP_MODE_FAST) begin
                        nxt_st.ctrl.print_strobe_n = 1'b0;
                    end else begin
                        nxt_st.ctrl.print_strobe_n = st_ff.rd;
                        if (st_ff.addr) begin
                            nxt_st.ctrl.select_in_n = 1'b0;
                        end else begin
                            nxt_st.ctrl.auto_line_feed_n = 1'b0;
                        end
                    end
                end
            end
            ppp_pkg::PPP_ST_STROBE: begin
                if (st_ff.cnt == '0) begin
                    if (st_ff.rd) begin
                        nxt_st.rsp = sy_data;
                        nxt_st.rsp_v = 1'b1;
                    end
                    nxt_st.ctrl.print_strobe_n = 1'b1;
                    if (st_ff.mode == ppp_pkg::PPP_MODE_FAST) begin
                        nxt_st.ctrl.auto_line_feed_n = 1'b1;
                        nxt_st.ctrl.select_in_n = 1'b1;
                    end
                    nxt_st.cnt = cyc(ppp_pkg::HOLD_CYC);
                    nxt_st.fsm = ppp_pkg::PPP_ST_HOLD;
                end
            end
            ppp_pkg::PPP_ST_HOLD: begin
                if (st_ff.cnt == '0) begin
                    nxt_st.fsm = (st_ff.mode == ppp_pkg::PPP_MODE_FAST) ?
                        ppp_pkg::PPP_ST_IDLE : ppp_pkg::PPP_ST_WAIT;
                end
            end
            ppp_pkg::PPP_ST_WAIT: begin
                // Falling ack ends a compatible transfer
                if (ack_fall || st_ff.ack_seen) begin
                    nxt_st.fsm = ppp_pkg::PPP_ST_IDLE;
                end
            end
            default: begin
                nxt_st.fsm = ppp_pkg::PPP_ST_IDLE;
            end
        endcase
        nxt_st.irq7_oe = irq_enable && !irq_line_sel;
        nxt_st.irq5_oe = irq_enable && irq_line_sel;
        nxt_st.irq7 = nxt_st.irq7_oe && !sy_in[3] && st_ff.ack_prev;
        nxt_st.irq5 = nxt_st.irq5_oe && !sy_in[3] && st_ff.ack_prev;
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            st_ff <= '0;
            st_ff.mode <= ppp_pkg::ppp_mode_t'(ppp_pkg::MODE_RST);
            st_ff.oe <= 8'hff;
            st_ff.ctrl <= 4'hf;
            st_ff.ack_prev <= 1'b1;
            st_ff.dout <= ppp_pkg::DATA_RST;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign req_ready = st_ff.ready;
    assign rsp_valid = st_ff.rsp_v;
    assign rsp_data = st_ff.rsp;
    assign status = st_ff.stat;
    assign ctrl = st_ff.ctrl;
    assign port_data_out = st_ff.dout;
    assign port_data_oe = st_ff.oe;
    assign data_buffer_direction = st_ff.dir;
    assign irq7_out = st_ff.irq7;
    assign irq7_oe = st_ff.irq7_oe;
    assign irq5_out = st_ff.irq5;
    assign irq5_oe = st_ff.irq5_oe;

    a_compat_dir_low: assert property (@(posedge clk) disable iff (reset)
        st_ff.mode == ppp_pkg::PPP_MODE_COMPAT |-> !data_buffer_direction)
        else $error("direction high in compatibility mode");
    a_dir_vs_oe: assert property (@(posedge clk) disable iff (reset)
        data_buffer_direction |-> port_data_oe == 8'h00)
        else $error("bus driven while direction is input");
    a_compat_drive: assert property (@(posedge clk) disable iff (reset)
        st_ff.mode == ppp_pkg::PPP_MODE_COMPAT |-> port_data_oe == 8'hff)
        else $error("bus released in compatibility mode");
    a_strobe_data: assert property (@(posedge clk) disable iff (reset)
        $fell(ctrl.print_strobe_n) && st_ff.mode != ppp_pkg::PPP_MODE_FAST
        |-> port_data_oe == (st_ff.rd ? 8'h00 : 8'hff) &&
        $stable(port_data_out))
        else $error("strobe without stable driven data");
    a_fast_read: assert property (@(posedge clk) disable iff (reset)
        st_ff.mode == ppp_pkg::PPP_MODE_FAST && st_ff.rd &&
        st_ff.fsm == ppp_pkg::PPP_ST_STROBE |-> ctrl.print_strobe_n)
        else $error("write strobe during fast read");
    // data strobe pulse in fast mode
    a_fast_dstb: assert property (@(posedge clk) disable iff (reset)
        st_ff.mode == ppp_pkg::PPP_MODE_FAST &&
        $fell(ctrl.auto_line_feed_n) |-> !ctrl.auto_line_feed_n [*2])
        else $error("data strobe too short");
    a_init_follow: assert property (@(posedge clk) disable iff (reset)
        init_req |=> !ctrl.printer_init_n)
        else $error("init not asserted");
    a_fast_astb: assert property (@(posedge clk) disable iff (reset)
        st_ff.mode == ppp_pkg::PPP_MODE_FAST && $fell(ctrl.select_in_n)
        |-> st_ff.addr)
        else $error("address strobe on data cycle");
    a_irq_one: assert property (@(posedge clk) disable iff (reset)
        !(irq7_oe && irq5_oe))
        else $error("both interrupt lines driven");
    a_mode_reset: assert property (@(posedge clk)
        reset |=> st_ff.mode == ppp_pkg::PPP_MODE_COMPAT)
        else $error("mode not compatibility after reset");

endmodule

// ==== ppp_printer.sv ====
// Purpose: Behavioural printer on the far side of the port
// Assumes: Host strobes are active low
// Notes: Acks every print strobe after ack_delay cycles
`timescale 1ns/1ps
module ppp_printer (
    input wire logic clk,
    input wire logic print_strobe_n,
    input wire logic [7:0] port_data_out,
    input wire logic [7:0] port_data_oe,
    input wire logic data_buffer_direction,
    input wire logic hold_busy,
    input wire logic [7:0] ack_delay,
    input wire logic [7:0] rd_byte,
    output logic [7:0] port_data_in,
    output logic peripheral_busy,
    output logic peripheral_ack_n,
    output logic [7:0] latched,
    output logic lat_ev
);
    logic [7:0] last = 8'h00;
    logic engaged = 1'b0;
    // wire level
    // Undriven bits carry rd_byte when direction is high, else toggle so a stale byte never passes
    assign port_data_in = (port_data_out & port_data_oe) |
        ((data_buffer_direction ? rd_byte : ~last) & ~port_data_oe);
    always @(posedge clk) last <= port_data_in;
    assign peripheral_busy = engaged | hold_busy;
    initial begin
        peripheral_ack_n = 1'b1;
        lat_ev = 1'b0;
        latched = 8'h00;
        forever begin
            @(negedge print_strobe_n);
            latched = port_data_out;
            lat_ev = 1'b1;
            engaged = 1'b1;
            @(posedge print_strobe_n);
            lat_ev = 1'b0;
            repeat (ack_delay) @(posedge clk);
            #1 peripheral_ack_n = 1'b0;
            repeat (4) @(posedge clk);
            #1 peripheral_ack_n = 1'b1;
            engaged = 1'b0;
        end
    end
endmodule

// ==== ppp_sync.sv ====
// Purpose: Three-stage input synchroniser with agreement check
// Assumes: Input is asynchronous to clk
// Notes: Output changes only when stages two and three agree
`timescale 1ns/1ps
module ppp_sync #(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] RST_VAL = '0
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic [WIDTH-1:0] din,
    output logic [WIDTH-1:0] dout
);

    typedef struct packed {
        logic [WIDTH-1:0] s1;
        logic [WIDTH-1:0] s2;
        logic [WIDTH-1:0] s3;
        logic [WIDTH-1:0] q;
    } ppp_sync_state_t;

    ppp_sync_state_t st_ff;
    ppp_sync_state_t nxt_st;

    always_comb begin
        nxt_st = st_ff;
        nxt_st.s1 = din;
        nxt_st.s2 = st_ff.s1;
        nxt_st.s3 = st_ff.s2;
        // Per-bit agreement filters a single-cycle metastable glitch
        for (int i = 0; i < WIDTH; i++) begin
            if (st_ff.s2[i] == st_ff.s3[i]) begin
                nxt_st.q[i] = st_ff.s3[i];
            end
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            st_ff <= '{s1: RST_VAL, s2: RST_VAL, s3: RST_VAL, q: RST_VAL};
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign dout = st_ff.q;

endmodule

// ==== tb_ppp_port.sv ====
// Purpose: Self-checking bench for the parallel printer port
// Assumes: Far side is the behavioural printer model
// Notes: Full strobe timing, a byte takes about 500 cycles
`timescale 1ns/1ps
module tb_ppp_port;
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic [1:0] mode_sel = 2'h0;
    logic irq_line_sel = 1'b0;
    logic irq_enable = 1'b0;
    logic auto_feed_req = 1'b0;
    logic init_req = 1'b0;
    logic select_req = 1'b0;
    logic req_valid = 1'b0;
    logic req_read = 1'b0;
    logic req_addr = 1'b0;
    logic [7:0] req_data = 8'h00;
    logic hold_busy = 1'b0;
    logic [7:0] ack_delay = 8'h02;
    logic [7:0] rd_byte = 8'h00;
    logic peripheral_fault_n = 1'b1;
    logic paper_out = 1'b0;
    logic peripheral_selected = 1'b0;
    logic req_ready, rsp_valid, data_buffer_direction, lat_ev;
    logic peripheral_busy, peripheral_ack_n;
    logic irq7_out, irq7_oe, irq5_out, irq5_oe;
    logic [7:0] rsp_data, port_data_out, port_data_oe, port_data_in;
    logic [7:0] latched, s_out, s_oe, s_rsp, d;
    logic [7:0] fast_ctrl [3] = '{8'h03, 8'h06, 8'h0b};
    ppp_pkg::ppp_status_t status;
    ppp_pkg::ppp_ctrl_t ctrl, s_ctrl;
    logic s_dir, s_got, s_dirhi, strb;
    int n_errors = 0;
    int n_tests = 0;
    int cyc = 0;
    int irq_cnt = 0;
    int s_lead, s_width, i, k;
    logic [7:0] exp_q[$];

    ppp_port dut_u (
        .clk, .reset, .mode_sel, .irq_line_sel, .irq_enable,
        .auto_feed_req, .init_req, .select_req, .req_valid, .req_read,
        .req_addr, .req_data, .req_ready, .rsp_valid, .rsp_data,
        .status, .ctrl, .port_data_out, .port_data_oe, .port_data_in,
        .data_buffer_direction, .peripheral_busy, .peripheral_ack_n,
        .peripheral_fault_n, .paper_out, .peripheral_selected,
        .irq7_out, .irq7_oe, .irq5_out, .irq5_oe
    );
    ppp_printer prn_u (
        .clk, .print_strobe_n(ctrl.print_strobe_n), .port_data_out,
        .port_data_oe, .data_buffer_direction, .hold_busy, .ack_delay,
        .rd_byte, .port_data_in, .peripheral_busy, .peripheral_ack_n,
        .latched, .lat_ev
    );

    always #2 clk = ~clk;

    task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_errors++;
            $display("[FAIL] %0t byte %h expected %h", $time, got, exp);
        end
    endtask

    task automatic chk_bit(input logic got, input logic exp);
        n_tests++;
        if (got !== exp) begin
            n_errors++;
            $display("[FAIL] %0t bit %b expected %b", $time, got, exp);
        end
    endtask

    task automatic results();
        $display("tests %0d errors %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // One request; pins are snapshot when the mode's strobe first falls
    task automatic xfer(input logic [1:0] m, input logic rd,
                        input logic ad, input logic [7:0] dat);
        mode_sel = m;
        req_read = rd;
        req_addr = ad;
        req_data = dat;
        s_got = 1'b0;
        s_dirhi = 1'b0;
        s_rsp = 8'h00;
        s_width = 0;
        s_lead = -1;
        for (i = 0; i < 3000 && req_ready !== 1'b1; i++) @(negedge clk);
        req_valid = 1'b1;
        @(negedge clk);
        req_valid = 1'b0;
        for (i = 0; i < 3000; i++) begin
            @(negedge clk);
            strb = m != 2'h2 ? ctrl.print_strobe_n :
                ad ? ctrl.select_in_n : ctrl.auto_line_feed_n;
            if (strb === 1'b0) s_width++;
            if (strb === 1'b0 && s_lead < 0) begin
                s_lead = i;
                s_ctrl = ctrl;
                s_out = port_data_out;
                s_oe = port_data_oe;
                s_dir = data_buffer_direction;
            end
            if (data_buffer_direction === 1'b1) s_dirhi = 1'b1;
            if (rsp_valid === 1'b1) begin
                s_got = 1'b1;
                s_rsp = rsp_data;
            end
            if (req_ready === 1'b1) break;
        end
        chk_bit(i < 3000, 1'b1);
    endtask

    always @(posedge lat_ev) begin
        if (exp_q.size() > 0) chk_byte(latched, exp_q.pop_front());
    end

    // Hang guard; a run needs about 6500 cycles
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (irq7_out === 1'b1 || irq5_out === 1'b1) irq_cnt <= irq_cnt + 1;
        if (cyc == 30000) begin
            n_errors++;
            results();
        end
    end

    initial begin
        void'($urandom(72));
        repeat (19) @(negedge clk);
        chk_byte({4'h0, ctrl}, 8'h0f);
        chk_bit(data_buffer_direction, 1'b0);
        chk_bit(req_ready, 1'b0);
        @(negedge clk);
        reset = 1'b0;
        irq_enable = 1'b1;
        repeat (2) @(negedge clk);
        chk_bit(irq7_oe & ~irq5_oe, 1'b1);
        for (k = 0; k < 4; k++) begin
            d = 8'($urandom);
            ack_delay = 8'($urandom_range(200, 0));
            exp_q.push_back(d);
            xfer(2'h0, 1'b0, 1'b0, d);
            chk_byte(s_out, d);
            chk_byte(s_oe, 8'hff);
            chk_bit(s_dirhi, 1'b0);
            chk_byte(8'(s_lead + 1), 8'(ppp_pkg::SETUP_CYC));
            chk_byte(8'(s_width), 8'(ppp_pkg::STROBE_CYC));
        end
        chk_byte(8'(exp_q.size()), 8'h00);
        chk_bit(irq_cnt > 0, 1'b1);
        xfer(2'h0, 1'b1, 1'b0, 8'h00);
        chk_bit(s_got, 1'b0);
        chk_bit(s_dirhi, 1'b0);
        hold_busy = 1'b1;
        fork
            begin
                repeat (400) @(negedge clk);
                hold_busy = 1'b0;
            end
        join_none
        d = 8'($urandom);
        exp_q.push_back(d);
        xfer(2'h0, 1'b0, 1'b0, d);
        chk_bit(s_lead > 390, 1'b1);
        irq_line_sel = 1'b1;
        irq_cnt = 0;
        for (k = 0; k < 2; k++) begin
            d = 8'($urandom);
            exp_q.push_back(d);
            xfer(2'h1, 1'b0, 1'b0, d);
            chk_byte(s_out, d);
            chk_bit(s_dir, 1'b0);
            rd_byte = 8'($urandom);
            xfer(2'h1, 1'b1, 1'b0, 8'h00);
            chk_byte(s_rsp, rd_byte);
            chk_bit(s_dir, 1'b1);
            chk_byte(s_oe, 8'h00);
        end
        chk_bit(irq5_oe & ~irq7_oe, 1'b1);
        chk_bit(irq_cnt > 0, 1'b1);
        // Fast mode: data write, address write, data read
        for (k = 0; k < 3; k++) begin
            d = 8'($urandom);
            rd_byte = 8'($urandom);
            xfer(2'h2, k == 2, k == 1, d);
            chk_byte({4'h0, s_ctrl}, fast_ctrl[k]);
            chk_bit(s_dir, k == 2);
            chk_byte(k == 2 ? s_rsp : s_out, k == 2 ? rd_byte : d);
            chk_byte(8'(s_width), 8'(ppp_pkg::STROBE_CYC));
        end
        mode_sel = 2'h0;
        for (k = 0; k < 2; k++) begin
            init_req = k[0];
            select_req = k[0];
            auto_feed_req = k[0];
            peripheral_fault_n = 1'($urandom);
            paper_out = 1'($urandom);
            peripheral_selected = 1'($urandom);
            irq_enable = k[0];
            d = {5'h0, ~peripheral_fault_n, paper_out, peripheral_selected};
            repeat (8) @(negedge clk);
            chk_byte({4'h0, ctrl}, k ? 8'h08 : 8'h0f);
            chk_byte({3'h0, status}, d);
            chk_bit(irq7_oe | irq5_oe, k[0]);
        end
        results();
    end
endmodule
